// *** bench/rps_top_assertions.sv ***
// port assertions for the registered prom core
`timescale 1ns/10ps
module rps_chk (
    input logic        I_CLOCK,
    input logic        I_RESET_N,
    input logic        I_AWVALID,
    input logic        O_AWREADY,
    input logic        I_WVALID,
    input logic        O_WREADY,
    input logic [1:0]  O_BRESP,
    input logic        O_BVALID,
    input logic        I_BREADY,
    input logic [7:0]  I_ARADDR,
    input logic        I_ARVALID,
    input logic        O_ARREADY,
    input logic [31:0] O_RDATA,
    input logic [1:0]  O_RRESP,
    input logic        O_RVALID,
    input logic        I_RREADY,
    input logic        I_PIPE_LOAD_CLOCK,
    input logic        I_MULTI_FUNCTION_PIN,
    input logic [3:0]  O_DQ,
    input logic        O_DQ_OE
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RESET_N);
    b_hold_a: assert property (O_BVALID && !I_BREADY |=>
        O_BVALID && $stable(O_BRESP)) else $error("bresp dropped");
    b_done_a: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("bvalid stuck");
    r_hold_a: assert property (O_RVALID && !I_RREADY |=>
        O_RVALID && $stable(O_RDATA)) else $error("rdata dropped");
    wr_answer_a: assert property (I_AWVALID && O_AWREADY && I_WVALID
        && O_WREADY |=> O_BVALID && !O_AWREADY) else $error("no bvalid");
    rd_answer_a: assert property (I_ARVALID && O_ARREADY |=>
        O_RVALID && !O_ARREADY) else $error("no rvalid");
    rd_unmapped_a: assert property (I_ARVALID && O_ARREADY
        && I_ARADDR > 8'h08 |=> O_RRESP == 2'b10 && O_RDATA == 32'h0)
        else $error("unmapped read not refused");
    dq_hold_a: assert property (
        !I_PIPE_LOAD_CLOCK [*8] |=> $stable(O_DQ)) else $error("dq moved");
    oe_on_a: assert property (
        !I_MULTI_FUNCTION_PIN [*8] |-> O_DQ_OE) else $error("oe not on");
    oe_off_a: assert property (
        I_MULTI_FUNCTION_PIN [*8] |-> !O_DQ_OE) else $error("oe not off");
endmodule
bind rps_top rps_chk u_chk (.I_CLOCK, .I_RESET_N, .I_AWVALID, .O_AWREADY,
    .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR,
    .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY,
    .I_PIPE_LOAD_CLOCK, .I_MULTI_FUNCTION_PIN, .O_DQ, .O_DQ_OE);

// *** bench/rps_wire.sv ***
// data wire shared by the core and the diagnostic controller
`timescale 1ns/10ps
module rps_wire (
    input  wire       i_clock,
    input  wire [3:0] i_dev_dq,
    input  wire       i_dev_oe,
    input  wire [3:0] i_ctl_dq,
    input  wire       i_ctl_oe,
    output reg  [3:0] o_wire
);
    reg [3:0] last = 4'h0;
    always @(posedge i_clock)
        last <= o_wire;
    // two-way port
    // no pull: a floating wire flips each cycle so stale data never matches
    always @*
        if (i_dev_oe)
            o_wire = i_dev_dq;
        else if (i_ctl_oe)
            o_wire = i_ctl_dq;
        else
            o_wire = ~last;
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the registered prom core
`timescale 1ns/10ps
module tb_top;
    logic        ck, rn, awv, wv, br, arv, rr, pk, dk, sd, pin, coe;
    logic [7:0]  awa, ara;
    logic [31:0] wd, d;
    logic [3:0]  ws, cdq, s;
    logic [1:0]  r;
    logic [11:0] ad;
    wire         awr, wrr, bv, arr, rv, oe, sq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [3:0]  dqo, dqw;
    int          bad_count, checks_done;
    bit          lag;
    logic [15:0] rows [4] = '{16'h0005, 16'hfffa, 16'h0a0f, 16'h0014};
    rps_top dut (.I_CLOCK(ck), .I_RESET_N(rn), .I_AWADDR(awa),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws),
        .I_WVALID(wv), .O_WREADY(wrr), .O_BRESP(bresp), .O_BVALID(bv),
        .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr),
        .I_ADDR(ad), .I_PIPE_LOAD_CLOCK(pk), .I_SHADOW_SHIFT_CLOCK(dk),
        .I_SERIAL_IN_CTL(sd), .I_MULTI_FUNCTION_PIN(pin), .I_DQ(dqw),
        .O_DQ(dqo), .O_DQ_OE(oe), .O_SERIAL_OUT(sq));
    rps_wire u_wire (.i_clock(ck), .i_dev_dq(dqo), .i_dev_oe(oe),
        .i_ctl_dq(cdq), .i_ctl_oe(coe), .o_wire(dqw));
    initial
    begin
        ck = 0;
        forever #5 ck = ~ck;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] v, e, input string n);
        checks_done++;
        if (v !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, v);
        end
    endtask
    task wr(input [7:0] a, input [31:0] x, input [3:0] st, input [1:0] er);
        int n;
        bit done;
        done = 0;
        @(posedge ck);
        awa <= a;
        wd  <= x;
        ws  <= st;
        awv <= 1;
        wv  <= 1;
        // lag keeps the ready low until the answer shows
        br  <= !lag;
        for (n = 0; n < 50 && !done; n++)
        begin
            @(posedge ck);
            if (awv && awr)
                awv <= 0;
            if (wv && wrr)
                wv <= 0;
            if (bv && br)
            begin
                chk(bresp, er, "bresp");
                br <= 0;
                done = 1;
            end
            else if (bv)
                br <= 1;
        end
        if (!done)
        begin
            bad_count++;
            end_of_test;
        end
    endtask
    task rd(input [7:0] a);
        int n;
        bit done;
        done = 0;
        @(posedge ck);
        ara <= a;
        arv <= 1;
        rr  <= !lag;
        for (n = 0; n < 50 && !done; n++)
        begin
            @(posedge ck);
            if (arv && arr)
                arv <= 0;
            if (rv && rr)
            begin
                d = rdata;
                r = rresp;
                rr <= 0;
                done = 1;
            end
            else if (rv)
                rr <= 1;
        end
        if (!done)
        begin
            bad_count++;
            end_of_test;
        end
    endtask
    // pins pass a three-flop filter, so pulses are held several clocks
    task pulse(input bit sh);
        repeat (6) @(posedge ck);
        if (sh)
            dk <= 1;
        else
            pk <= 1;
        repeat (4) @(posedge ck);
        dk <= 0;
        pk <= 0;
        repeat (8) @(posedge ck);
    endtask
    task do_reset;
        rn <= 0;
        repeat (5) @(posedge ck);
        chk({oe, sq, dqo}, 6'h0, "reset pins");
        rn <= 1;
        @(posedge ck);
    endtask
    initial
    begin
        {rn, awv, wv, br, arv, rr, pk, dk, sd, pin, coe} = 0;
        awa = 0;
        ara = 0;
        wd = 0;
        ws = 0;
        cdq = 0;
        ad = 0;
        lag = 0;
        bad_count = 0;
        checks_done = 0;
        do_reset;
        foreach (rows[i])
        begin
            ad <= rows[i][15:4];
            pulse(0);
            chk(dqo, rows[i][3:0], "array word");
        end
        chk(oe, 1, "oe");
        s = 0;
        for (int i = 3; i >= 0; i--)
        begin
            sd <= 1'(4'b1011 >> i);
            s = {s[2:0], 1'(4'b1011 >> i)};
            pulse(1);
            chk(sq, s[3], "serial out");
        end
        rd(8'h04);
        chk(d, 32'h5b4, "status");
        wr(8'h00, 32'h1, 4'hf, 2'b00);
        for (int v = 1; v >= 0; v--)
        begin
            sd <= 1'(v);
            repeat (6) @(posedge ck);
            chk(sq, v, "pass through");
        end
        pulse(0);
        chk(dqo, 4'hb, "from shadow");
        pin <= 1;
        cdq <= 4'h6;
        repeat (8) @(posedge ck);
        chk(oe, 0, "oe off");
        coe <= 1;
        pulse(1);
        sd <= 1;
        cdq <= 4'h9;
        pulse(1);
        rd(8'h04);
        chk(d[9:0], 10'h26b, "shadow load");
        pulse(0);
        pin <= 0;
        coe <= 0;
        repeat (8) @(posedge ck);
        chk({oe, dqo}, 5'h16, "forced");
        rd(8'h08);
        chk(d, 32'h6, "loads");
        lag = 1;
        rd(8'h0c);
        chk(r, 2'b10, "unmapped resp");
        chk(d, 32'h0, "unmapped data");
        wr(8'h04, 32'h0, 4'hf, 2'b10);
        lag = 0;
        wr(8'h00, 32'h0, 4'h0, 2'b00);
        rd(8'h00);
        chk(d, 32'h1, "strobe");
        do_reset;
        rd(8'h00);
        chk(d, 32'h0, "ctrl reset");
        end_of_test;
    end
endmodule

// *** hw/rps_defs.vh ***
// constants for the registered prom with shadow diagnostics
`ifndef RPS_DEFS_VH
`define RPS_DEFS_VH

`define RPS_ADDR_W        12
`define RPS_WORDS         4096
`define RPS_DATA_W        4

`define RPS_ARCH_ASYNC_EN   2'b00
`define RPS_ARCH_SYNC_EN    2'b01
`define RPS_ARCH_ASYNC_INIT 2'b10
`define RPS_ARCH_SYNC_INIT  2'b11

`define RPS_REG_CTRL      8'h00
`define RPS_REG_STATUS    8'h04
`define RPS_REG_LOADS     8'h08

`define RPS_CTRL_MODE_BIT 0
`define RPS_CTRL_RESET    32'h0000_0000
`define RPS_CTRL_MODE_RST 1'b0
`define RPS_ST_PIPE_LSB   0
`define RPS_ST_SHAD_LSB   4
`define RPS_ST_OE_BIT     8
`define RPS_ST_PIN_BIT    9
`define RPS_ST_ADDR_LSB   10

`define RPS_RESP_OKAY     2'b00
`define RPS_RESP_SLVERR   2'b10

`endif

// *** hw/rps_rom.v ***
// 4096 x 4 read-only array with registered read data
`timescale 1ns/10ps
`include "rps_defs.vh"
module rps_rom #(
    parameter [3:0] SEED = 4'h5
) (
    input  wire                   i_clock,
    input  wire [`RPS_ADDR_W-1:0] i_addr,
    output reg  [`RPS_DATA_W-1:0] o_data
);
    // contents fixed at build time, derived from address
    function [3:0] word_at;
        input [11:0] a;
        begin
            word_at = a[3:0] ^ a[7:4] ^ a[11:8] ^ SEED;
        end
    endfunction

    always @(posedge i_clock)
    begin
        o_data <= word_at(i_addr);
    end
endmodule

// *** hw/rps_sync.v ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module rps_sync #(
    parameter WIDTH = 1
) (
    input  wire             i_clock,
    input  wire             i_reset_n,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : bit_sync
            reg s1;
            reg s2;
            reg s3;
            reg q;
            // s1 feeds only s2 to keep metastability contained
            always @(posedge i_clock)
            begin
                if (!i_reset_n)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    q  <= 1'b0;
                end
                else
                begin
                    s1 <= i_async[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        q <= s3;
                end
            end
            assign o_sync[g] = q;
        end
    endgenerate
endmodule

// *** hw/rps_top.v ***
// registered prom core with shadow register and axi4-lite status port
// Behaviour
// R1: array of 4096 four-bit words, one word picked by 12-bit address
// R2: four-bit pipeline register sits between array and data pins
// R3: separate four-bit shadow register with serial shift, independent clock
// R4: shadow register can observe and force pipeline register in test mode
// R5: unprogrammed architecture makes multi-function pin asynchronous low enable
// R6: architecture may select sync enable, async init or sync init
// R7: pipeline register loads on pipeline clock rise, holds otherwise
// R8: pipeline source is array, shadow, or init word under sync init
// R9: data port drives pipeline value and feeds shadow parallel load
// R10: mode low: array feeds pipeline, shadow shifts up, serial out is bit 3
// R11: mode high: serial in low loads shadow from port, high holds
// R12: mode high: pipeline clock rise loads pipeline from shadow
// R13: sync enable changes drive on pipeline clock; async init acts at once
// R14: array, init word and architecture are build-time parameters
// R15: disabled outputs float while pipeline register keeps its value
`timescale 1ns/10ps
`include "rps_defs.vh"
module rps_top #(
    // R14: build-time contents
    parameter [1:0] ARCH      = `RPS_ARCH_ASYNC_EN,
    parameter [3:0] INIT_WORD = 4'h0,
    parameter [3:0] ROM_SEED  = 4'h5
) (
    input  wire        I_CLOCK,
    input  wire        I_RESET_N,
    input  wire [7:0]  I_AWADDR,
    input  wire        I_AWVALID,
    output reg         O_AWREADY,
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output reg         O_WREADY,
    output reg  [1:0]  O_BRESP,
    output reg         O_BVALID,
    input  wire        I_BREADY,
    input  wire [7:0]  I_ARADDR,
    input  wire        I_ARVALID,
    output reg         O_ARREADY,
    output reg  [31:0] O_RDATA,
    output reg  [1:0]  O_RRESP,
    output reg         O_RVALID,
    input  wire        I_RREADY,
    input  wire [11:0] I_ADDR,
    input  wire        I_PIPE_LOAD_CLOCK,
    input  wire        I_SHADOW_SHIFT_CLOCK,
    input  wire        I_SERIAL_IN_CTL,
    input  wire        I_MULTI_FUNCTION_PIN,
    input  wire [3:0]  I_DQ,
    output reg  [3:0]  O_DQ,
    output reg         O_DQ_OE,
    output reg         O_SERIAL_OUT
);
    localparam [1:0] ARCH_P = ARCH;

    wire [11:0] addr_s;
    wire [3:0]  dq_s;
    wire        pk_s;
    wire        dk_s;
    wire        sd_s;
    wire        mf_s;
    wire [3:0]  rom_q;

    reg         pk_d;
    reg         dk_d;
    reg  [3:0]  shadow;
    reg  [3:0]  next_shadow;
    reg  [3:0]  next_pipe;
    reg         next_oe;
    reg         mode;
    reg  [15:0] load_count;

    wire        pk_rise;
    wire        dk_rise;

    // pins come from outside this clock domain
    rps_sync #(.WIDTH(20)) u_sync (
        .i_clock   (I_CLOCK),
        .i_reset_n (I_RESET_N),
        .i_async   ({I_ADDR, I_DQ, I_PIPE_LOAD_CLOCK,
                     I_SHADOW_SHIFT_CLOCK, I_SERIAL_IN_CTL,
                     I_MULTI_FUNCTION_PIN}),
        .o_sync    ({addr_s, dq_s, pk_s, dk_s, sd_s, mf_s})
    );

    // R1: address selects one word
    rps_rom #(.SEED(ROM_SEED)) u_rom (
        .i_clock (I_CLOCK),
        .i_addr  (addr_s),
        .o_data  (rom_q)
    );

    assign pk_rise = pk_s & ~pk_d;
    assign dk_rise = dk_s & ~dk_d;

    always @(posedge I_CLOCK)
    begin
        if (!I_RESET_N)
        begin
            pk_d <= 1'b0;
            dk_d <= 1'b0;
        end
        else
        begin
            pk_d <= pk_s;
            dk_d <= dk_s;
        end
    end

    // shadow register, runs on its own clock edges only
    always @*
    begin
        next_shadow = shadow;
        if (dk_rise)
        begin
            if (!mode)
                // R10: serial shift upward
                next_shadow = {shadow[2:0], sd_s};
            else if (!sd_s)
                // R11: parallel load from port
                // R9: port is shadow input
                next_shadow = dq_s;
        end
    end

    // pipeline source selection
    always @*
    begin
        next_pipe = O_DQ;
        if (pk_rise)
        begin
            if (mode)
                // R12: shadow into pipeline
                // R4: force pipeline contents
                next_pipe = shadow;
            else if (ARCH_P == `RPS_ARCH_SYNC_INIT && !mf_s)
                // R8: sync init word
                next_pipe = INIT_WORD;
            else
                // R7: load array word
                next_pipe = rom_q;
        end
        // R13: async init, no clock needed
        if (ARCH_P == `RPS_ARCH_ASYNC_INIT && !mf_s)
            next_pipe = INIT_WORD;
    end

    // output enable per architecture
    always @*
    begin
        case (ARCH_P)
            `RPS_ARCH_ASYNC_EN:
                // R5: direct active-low enable
                next_oe = ~mf_s;
            `RPS_ARCH_SYNC_EN:
                // R13: enable sampled by pipeline clock
                next_oe = pk_rise ? ~mf_s : O_DQ_OE;
            default:
                // R6: init variants always drive
                next_oe = 1'b1;
        endcase
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RESET_N)
        begin
            shadow       <= 4'h0;
            O_DQ         <= 4'h0;
            O_DQ_OE      <= 1'b0;
            O_SERIAL_OUT <= 1'b0;
            load_count   <= 16'h0000;
        end
        else
        begin
            // R3: shadow independent of pipeline
            shadow  <= next_shadow;
            // R2: pipeline value drives pins
            // R15: value kept while disabled
            O_DQ    <= next_pipe;
            O_DQ_OE <= next_oe;
            // R10: serial out follows bit 3
            // R11: pass serial in through
            O_SERIAL_OUT <= mode ? sd_s : next_shadow[3];
            if (pk_rise)
                load_count <= load_count + 16'h0001;
        end
    end

    // axi4-lite write side
    reg        aw_full;
    reg        w_full;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    wire        aw_take;
    wire        w_take;
    wire        a_f;
    wire        d_f;
    wire        do_write;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire        next_aw_full;
    wire        next_w_full;
    wire        next_bvalid;

    assign aw_take      = I_AWVALID & O_AWREADY;
    assign w_take       = I_WVALID & O_WREADY;
    assign a_f          = aw_full | aw_take;
    assign d_f          = w_full | w_take;
    assign do_write     = a_f & d_f & ~O_BVALID;
    assign wr_addr      = aw_full ? aw_addr : I_AWADDR;
    assign wr_data      = w_full ? w_data : I_WDATA;
    assign wr_strb      = w_full ? w_strb : I_WSTRB;
    assign next_aw_full = a_f & ~do_write;
    assign next_w_full  = d_f & ~do_write;
    assign next_bvalid  = do_write | (O_BVALID & ~I_BREADY);

    always @(posedge I_CLOCK)
    begin
        if (!I_RESET_N)
        begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            O_BVALID  <= 1'b0;
            O_BRESP   <= `RPS_RESP_OKAY;
            mode      <= `RPS_CTRL_MODE_RST;
        end
        else
        begin
            aw_full   <= next_aw_full;
            w_full    <= next_w_full;
            O_AWREADY <= ~next_aw_full & ~next_bvalid;
            O_WREADY  <= ~next_w_full & ~next_bvalid;
            O_BVALID  <= next_bvalid;
            if (aw_take)
                aw_addr <= I_AWADDR;
            if (w_take)
            begin
                w_data <= I_WDATA;
                w_strb <= I_WSTRB;
            end
            if (do_write)
            begin
                // only control is writable; the rest answer an error
                if (wr_addr == `RPS_REG_CTRL)
                begin
                    O_BRESP <= `RPS_RESP_OKAY;
                    if (wr_strb[0])
                        mode <= wr_data[`RPS_CTRL_MODE_BIT];
                end
                else
                    O_BRESP <= `RPS_RESP_SLVERR;
            end
        end
    end

    // axi4-lite read side
    reg [31:0] rd_word;
    reg        rd_ok;
    wire       ar_take;
    wire       next_rvalid;

    assign ar_take     = I_ARVALID & O_ARREADY;
    assign next_rvalid = ar_take | (O_RVALID & ~I_RREADY);

    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (I_ARADDR)
            `RPS_REG_CTRL:
                rd_word[`RPS_CTRL_MODE_BIT] = mode;
            `RPS_REG_STATUS:
            begin
                rd_word[`RPS_ST_PIPE_LSB +: 4]  = O_DQ;
                rd_word[`RPS_ST_SHAD_LSB +: 4]  = shadow;
                rd_word[`RPS_ST_OE_BIT]         = O_DQ_OE;
                rd_word[`RPS_ST_PIN_BIT]        = mf_s;
                rd_word[`RPS_ST_ADDR_LSB +: 12] = addr_s;
            end
            `RPS_REG_LOADS:
                rd_word[15:0] = load_count;
            default:
                rd_ok = 1'b0;
        endcase
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RESET_N)
        begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h0000_0000;
            O_RRESP   <= `RPS_RESP_OKAY;
        end
        else
        begin
            O_ARREADY <= ~next_rvalid;
            O_RVALID  <= next_rvalid;
            if (ar_take)
            begin
                O_RDATA <= rd_word;
                O_RRESP <= rd_ok ? `RPS_RESP_OKAY : `RPS_RESP_SLVERR;
            end
        end
    end
endmodule
